// >>> flash_program_control.sv
// program transaction controller: link decode, page load, array walk, status
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_regs.svh"

// Function
// R1: program commands execute only while the write permit flag is set
// R2: write permit flag clears when any program operation ends
// R3: busy flag is 1 throughout the program operation, status stays readable
// R4: program to a protected sector is refused and sets program error flag
// R5: programming starts only when chip select rises at command end
// R6: hot or automotive grades must program each ECC unit once per erase
// R7: reprogramming a data unit without erase disables its ECC
// R8: with 2-bit detection on, a repeat pass fails with program error
// R9: page size 256 or 512 bytes by config three bit 4, size-aligned
// R10: one page program accepts from one bit up to a full page; launch here needs at least one whole data byte
// R11: host should write 16-byte aligned multiples for ECC and speed
// R12: load address wraps from page end to byte zero, overwriting
// R13: short loads program in sequence from the start, other bytes untouched
// R14: DDR needs even start address and even byte count; SDR any
// R15: secure region is 1024 bytes; upper address bits must be zero
// R16: secure programming starts 32-bit aligned and ends on 32-bit boundary
// R17: programming zeros into a locked secure area fails with program error
// R18: secure data ones leave cells alone; repeat pass disables ECC
// R19: lock-bit program sets the lock of the addressed sector
// R20: lock-bit program aborts when guard, permanent or freeze bit forbids
// R21: octal modes carry two command bytes; DDR uses both clock edges
// R22: serial and octal-input modes shift one command bit per rising edge
// R23: write enable command sets the write permit flag
// R24: clear-fail command clears error flags, works while busy, keeps permit
// R25: while busy, only the clear-fail command acts
// R26: after a program error busy holds until clear-fail arrives
module flash_program_control #(
   parameter int SECTOR_BITS  = 8,
   parameter int SECTOR_SHIFT = 18,
   parameter int PAGE_MAX     = 512
) (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   // link pins
   input  wire logic                      link_sck,
   input  wire logic                      link_cs_n,
   input  wire logic [7:0]                link_io,
   // configuration and protection
   input  wire logic [2:0]                link_proto,
   input  wire logic [7:0]                config_three_volatile,
   input  wire logic [7:0]                sector_protect_options,
   input  wire logic [7:0]                lock_freeze_reg,
   input  wire logic                      sector_protected,
   input  wire logic                      secure_region_locked,
   input  wire logic                      ecc2_enable,
   // array side
   input  wire logic                      arr_unit_prior,
   output var  flash_prog_pkg::arr_beat_t arr_beat,
   output logic                           ecc_unit_off,
   // status
   output logic [31:0]                    target_addr,
   output logic [7:0]                     status_one_volatile
);

   localparam int IDX_W      = $clog2(PAGE_MAX);
   localparam int SETTLE_CYC = (`PROG_SETTLE_NS * `CORE_CLK_MHZ + 999) / 1000;
   localparam int SET_W      = $clog2(SETTLE_CYC + 1);
   localparam int NSECT      = 1 << SECTOR_BITS;

   generate
      if (PAGE_MAX != 512 || SETTLE_CYC < 1 || SETTLE_CYC > 4096 ||
          SECTOR_SHIFT + SECTOR_BITS > 32) begin : g_bad
         $error("flash_program_control parameters out of range");
      end
   endgenerate

   // ************************************************************
   // link sampling and edges
   // ************************************************************
   logic [9:0] sync_out;
   logic       sck_d_ff;
   logic       cs_d_ff;

   link_sync #(.WIDTH(10), .RESET_VAL(10'h100)) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in ({link_sck, link_cs_n, link_io}),
      .sync_out (sync_out)
   );

   wire logic       sck_s = sync_out[9];
   wire logic       cs_s  = sync_out[8];
   wire logic [7:0] io_s  = sync_out[7:0];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sck_d_ff <= 1'b0;
         cs_d_ff  <= 1'b1;
      end else begin
         sck_d_ff <= sck_s;
         cs_d_ff  <= cs_s;
      end
   end

   wire flash_prog_pkg::proto_t proto = flash_prog_pkg::proto_t'(link_proto);
   wire logic ddr      = (proto == flash_prog_pkg::PROTO_8D8D8D);
   wire logic oct_cmd  = ddr || (proto == flash_prog_pkg::PROTO_8S8S8S);
   wire logic addr_ser = (proto == flash_prog_pkg::PROTO_1S1S1S) ||
                         (proto == flash_prog_pkg::PROTO_1S1S8S);
   wire logic data_ser = (proto == flash_prog_pkg::PROTO_1S1S1S);
   wire logic frame_start = cs_d_ff && !cs_s;
   // R5: launch on cs rise
   wire logic cs_rise  = !cs_d_ff && cs_s;
   // R21: ddr samples both edges
   wire logic beat     = !cs_s && ((sck_s && !sck_d_ff) || (ddr && !sck_s && sck_d_ff));

   // ************************************************************
   // byte assembly and phases
   // ************************************************************
   logic [2:0] bit_cnt_ff;
   logic [2:0] byte_idx_ff;
   logic [6:0] sh_ff;
   logic [8:0] data_cnt_ff;
   logic       got_data_ff;
   logic [7:0] op_ff;
   logic [31:0] addr_ff;

   // R21: two octal command bytes
   wire logic [2:0] cmd_len  = oct_cmd ? 3'h2 : 3'h1;
   wire logic [2:0] hdr_len  = cmd_len + `ADDR_BYTES;
   wire logic in_cmd   = byte_idx_ff < cmd_len;
   wire logic in_addr  = !in_cmd && (byte_idx_ff < hdr_len);
   wire logic in_data  = !in_cmd && !in_addr;
   // R22: serial command shifts one bit per rise
   wire logic lane_ser = in_cmd ? !oct_cmd : (in_addr ? addr_ser : data_ser);
   wire logic byte_done = beat && (!lane_ser || bit_cnt_ff == 3'h7);
   wire logic [7:0] byte_val = lane_ser ? {sh_ff, io_s[0]} : io_s;

   wire logic op_we   = (op_ff == `OP_WRITE_ENABLE);
   wire logic op_clr  = (op_ff == `OP_CLEAR_FAIL);
   wire logic op_page = (op_ff == `OP_PAGE_PROGRAM);
   wire logic op_sec  = (op_ff == `OP_SECURE_PROGRAM);
   wire logic op_lock = (op_ff == `OP_LOCK_PROGRAM);

   flash_prog_pkg::prog_state_t state_ff;
   flash_prog_pkg::prog_state_t nxt_state;
   wire logic busy = (state_ff != flash_prog_pkg::ST_IDLE);

   wire logic [2:0] nxt_bit_cnt  = lane_ser ? bit_cnt_ff + 3'h1 : 3'h0;
   wire logic [2:0] nxt_byte_idx = in_data ? byte_idx_ff : byte_idx_ff + 3'h1;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bit_cnt_ff  <= '0;
         byte_idx_ff <= '0;
         sh_ff       <= '0;
      end else if (frame_start) begin
         bit_cnt_ff  <= '0;
         byte_idx_ff <= '0;
      end else if (beat) begin
         bit_cnt_ff  <= nxt_bit_cnt;
         sh_ff       <= {sh_ff[5:0], io_s[0]};
         byte_idx_ff <= byte_done ? nxt_byte_idx : byte_idx_ff;
      end
   end

   // ************************************************************
   // page load
   // ************************************************************
   // R9: page size select
   wire logic [8:0] pmask = config_three_volatile[`CFG3_PAGE512_BIT] ?
                            `PAGE_MASK_LARGE : `PAGE_MASK_SMALL;
   // R14: ddr start forced even
   wire logic [8:0] start_off = addr_ff[IDX_W-1:0] & pmask & {8'hFF, !ddr};
   // R12: load index wraps inside the page
   wire logic [8:0] buf_idx = (start_off + data_cnt_ff) & pmask;
   // R25: no loading while busy
   wire logic buf_we = byte_done && in_data && !busy && (op_page || op_sec);
   wire logic addr_we = byte_done && in_addr && !busy;

   // R10: any length of one whole data byte or more accepted
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         op_ff       <= '0;
         addr_ff     <= '0;
         data_cnt_ff <= '0;
         got_data_ff <= 1'b0;
      end else begin
         op_ff       <= (byte_done && in_cmd && byte_idx_ff == 3'h0) ? byte_val : op_ff;
         addr_ff     <= addr_we ? {addr_ff[23:0], byte_val} : addr_ff;
         data_cnt_ff <= frame_start ? 9'h0 : data_cnt_ff + {8'h0, buf_we};
         got_data_ff <= !frame_start && (got_data_ff || buf_we);
      end
   end

   // ************************************************************
   // launch decisions
   // ************************************************************
   logic [NSECT-1:0] lock_ff;
   logic [8:0]       walk_idx_ff;
   logic [8:0]       run_mask_ff;
   logic             run_sec_ff;
   logic [SET_W-1:0] settle_ff;
   logic [7:0]       walk_data;
   logic             walk_valid;
   logic [7:0]       status_ff;
   flash_prog_pkg::arr_beat_t beat_ff;
   flash_prog_pkg::arr_beat_t nxt_beat;
   logic             ecc_off_ff;

   wire logic wpf      = status_ff[`STS_WPF_BIT];
   wire logic cmd_done = byte_idx_ff >= cmd_len;
   wire logic hdr_done = byte_idx_ff >= hdr_len;
   wire logic [SECTOR_BITS-1:0] sector = addr_ff[SECTOR_SHIFT +: SECTOR_BITS];
   // R24: clear accepted even while busy
   wire logic clr_now  = cs_rise && op_clr && cmd_done;
   // R23: write enable only when idle
   wire logic we_now   = cs_rise && op_we && cmd_done && !busy;
   // R1: program needs write permit
   wire logic launch_page = cs_rise && !busy && wpf && (op_page || op_sec) && got_data_ff;
   wire logic launch_lock = cs_rise && !busy && wpf && op_lock && hdr_done;
   // R4: protected sector refuses page program
   wire logic page_prot = op_page && (sector_protected || lock_ff[sector]);
   // R20: lock program guards, each active low
   wire logic lock_guard = !sector_protect_options[`SPO_GUARD_BIT] ||
                           !sector_protect_options[`SPO_PERM_BIT] ||
                           !lock_freeze_reg[`FREEZE_BIT];

   // R19: persistent lock per sector
   generate
      for (genvar s = 0; s < NSECT; s++) begin : g_lock
         wire logic set_lock = launch_lock && !lock_guard && (sector == SECTOR_BITS'(s));
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               lock_ff[s] <= 1'b0;
            end else begin
               lock_ff[s] <= lock_ff[s] | set_lock;
            end
         end
      end
   endgenerate

   // ************************************************************
   // array walk
   // ************************************************************
   page_buffer #(.DATA_W(8), .DEPTH(PAGE_MAX)) u_buf (
      .core_clk (core_clk),
      .rst      (rst),
      .clear    (frame_start && !busy),
      .wr_en    (buf_we),
      .wr_idx   (buf_idx),
      .wr_data  (byte_val),
      .rd_idx   (walk_idx_ff),
      .rd_data  (walk_data),
      .rd_valid (walk_valid)
   );

   wire logic in_walk  = (state_ff == flash_prog_pkg::ST_WALK);
   wire logic walk_end = (walk_idx_ff == run_mask_ff);
   // R17: zeros into locked secure area fail
   wire logic sec_lock_hit = in_walk && run_sec_ff && secure_region_locked &&
                             walk_valid && (walk_data != 8'hFF);
   // R7: repeated unit loses ECC
   wire logic prior_hit  = beat_ff.we && arr_unit_prior;
   // R8: repeat pass fails with 2-bit detection
   wire logic prior_fail = prior_hit && ecc2_enable && !beat_ff.secure;
   wire logic [31:0] page_addr = {addr_ff[31:IDX_W],
                                  (addr_ff[IDX_W-1:0] & ~run_mask_ff) | walk_idx_ff};

   always_comb begin
      // R13: only loaded bytes, in order; R18: ones leave cells alone
      nxt_beat.we     = in_walk && walk_valid && !sec_lock_hit && !prior_fail;
      nxt_beat.secure = run_sec_ff;
      nxt_beat.addr   = run_sec_ff ? (page_addr & `SECURE_ADDR_MASK) : page_addr;
      nxt_beat.data   = walk_data;
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         flash_prog_pkg::ST_IDLE: begin
            if (launch_page) begin
               nxt_state = page_prot ? flash_prog_pkg::ST_FAIL : flash_prog_pkg::ST_WALK;
            end else if (launch_lock) begin
               nxt_state = lock_guard ? flash_prog_pkg::ST_FAIL : flash_prog_pkg::ST_SETTLE;
            end
         end
         flash_prog_pkg::ST_WALK: begin
            if (sec_lock_hit || prior_fail) begin
               nxt_state = flash_prog_pkg::ST_FAIL;
            end else if (walk_end) begin
               nxt_state = flash_prog_pkg::ST_SETTLE;
            end
         end
         flash_prog_pkg::ST_SETTLE: begin
            if (prior_fail) begin
               nxt_state = flash_prog_pkg::ST_FAIL;
            end else if (settle_ff == '0) begin
               nxt_state = flash_prog_pkg::ST_IDLE;
            end
         end
         flash_prog_pkg::ST_FAIL: begin
            // R26: busy holds until cleared
            if (clr_now) begin
               nxt_state = flash_prog_pkg::ST_IDLE;
            end
         end
         default: nxt_state = flash_prog_pkg::ST_IDLE;
      endcase
   end

   // ************************************************************
   // status one
   // ************************************************************
   wire logic fail_set = (nxt_state == flash_prog_pkg::ST_FAIL) &&
                         (state_ff != flash_prog_pkg::ST_FAIL);
   wire logic done_ok  = (state_ff == flash_prog_pkg::ST_SETTLE) &&
                         (nxt_state == flash_prog_pkg::ST_IDLE);
   logic [7:0] nxt_status;

   always_comb begin
      nxt_status = 8'h00;
      // R3: busy follows the operation
      nxt_status[`STS_BUSY_BIT]      = (nxt_state != flash_prog_pkg::ST_IDLE);
      // R2: permit clears at the end
      nxt_status[`STS_WPF_BIT]       = we_now || (wpf && !fail_set && !done_ok);
      // R24: set wins over clear
      nxt_status[`STS_PROG_ERR_BIT]  = fail_set || (status_ff[`STS_PROG_ERR_BIT] && !clr_now);
      nxt_status[`STS_ERASE_ERR_BIT] = status_ff[`STS_ERASE_ERR_BIT] && !clr_now;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff    <= flash_prog_pkg::ST_IDLE;
         status_ff   <= `STATUS_RESET;
         walk_idx_ff <= '0;
         run_mask_ff <= `PAGE_MASK_SMALL;
         run_sec_ff  <= 1'b0;
         settle_ff   <= '0;
         beat_ff     <= '0;
         ecc_off_ff  <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         status_ff   <= nxt_status;
         walk_idx_ff <= launch_page ? 9'h0 : walk_idx_ff + {8'h0, in_walk && !walk_end};
         run_mask_ff <= launch_page ? pmask : run_mask_ff;
         run_sec_ff  <= launch_page ? op_sec : run_sec_ff;
         settle_ff   <= (state_ff != flash_prog_pkg::ST_SETTLE) ? SET_W'(SETTLE_CYC - 1) :
                        settle_ff - SET_W'(settle_ff != '0);
         beat_ff     <= nxt_beat;
         ecc_off_ff  <= prior_hit;
      end
   end

   assign arr_beat            = beat_ff;
   assign ecc_unit_off        = ecc_off_ff;
   assign target_addr         = addr_ff;
   assign status_one_volatile = status_ff;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   exec_needs_wpf_a: assert property ( // R1
      (!busy && nxt_state != flash_prog_pkg::ST_IDLE) |-> wpf)
      else $error("program began without write permit");
   wpf_clear_done_a: assert property ( // R2
      done_ok |=> !status_ff[`STS_WPF_BIT])
      else $error("write permit survived program end");
   busy_tracks_a: assert property ( // R3
      status_ff[`STS_BUSY_BIT] == busy)
      else $error("busy flag disagrees with operation");
   protect_fail_a: assert property ( // R4
      (launch_page && page_prot) |=> (state_ff == flash_prog_pkg::ST_FAIL)
         && status_ff[`STS_PROG_ERR_BIT] && !arr_beat.we)
      else $error("protected page program not refused");
   launch_on_cs_a: assert property ( // R5
      (!busy && nxt_state != flash_prog_pkg::ST_IDLE) |-> cs_rise)
      else $error("program launched without chip select rise");
   wrap_page_a: assert property ( // R12
      buf_we |-> ((buf_idx & ~pmask) == 9'h0) && (got_data_ff || buf_idx == start_off))
      else $error("page load left the page");
   sec_lock_a: assert property ( // R17
      sec_lock_hit |=> (state_ff == flash_prog_pkg::ST_FAIL) && status_ff[`STS_PROG_ERR_BIT])
      else $error("locked secure zero did not fail");
   lock_abort_a: assert property ( // R20
      (launch_lock && lock_guard) |=> (state_ff == flash_prog_pkg::ST_FAIL) &&
         $stable(lock_ff))
      else $error("guarded lock program not aborted");
   clear_err_a: assert property ( // R24
      (clr_now && state_ff == flash_prog_pkg::ST_FAIL) |=>
         !status_ff[`STS_PROG_ERR_BIT] && !busy && $stable(status_ff[`STS_WPF_BIT]))
      else $error("clear did not release error");
   fail_hold_a: assert property ( // R26
      (state_ff == flash_prog_pkg::ST_FAIL && !clr_now) |=>
         status_ff[`STS_BUSY_BIT] && (state_ff == flash_prog_pkg::ST_FAIL))
      else $error("busy dropped after error");
   busy_ignore_a: assert property ( // R25
      (busy && cs_rise && op_we) |=> $stable(status_ff[`STS_WPF_BIT]))
      else $error("write enable acted while busy");

   walk_done_c: cover property (done_ok && run_sec_ff == 1'b0);
   fail_seen_c: cover property (fail_set ##[1:20] clr_now);
   lock_set_c: cover property (launch_lock && !lock_guard);

endmodule : flash_program_control
`default_nettype wire

// >>> flash_prog_regs.svh
// constants for the flash program controller
`ifndef FLASH_PROG_REGS_SVH
`define FLASH_PROG_REGS_SVH

// status one bit positions
`define STS_BUSY_BIT       0
`define STS_WPF_BIT        1
`define STS_ERASE_ERR_BIT  5
`define STS_PROG_ERR_BIT   6
`define STATUS_RESET       8'h00
// configuration and protection bit positions
`define CFG3_PAGE512_BIT   4
`define SPO_GUARD_BIT      3
`define SPO_PERM_BIT       0
`define FREEZE_BIT         0
// opcodes, arbitrary plain values
`define OP_WRITE_ENABLE    8'h11
`define OP_CLEAR_FAIL      8'h22
`define OP_PAGE_PROGRAM    8'h33
`define OP_SECURE_PROGRAM  8'h44
`define OP_LOCK_PROGRAM    8'h55
// geometry
`define ADDR_BYTES         3'h4
`define PAGE_MASK_SMALL    9'h0FF
`define PAGE_MASK_LARGE    9'h1FF
`define SECURE_ADDR_MASK   32'h0000_03FF
// timing
`define CORE_CLK_MHZ       40
`define PROG_SETTLE_NS     2000

`endif

// >>> flash_prog_pkg.sv
// types shared by the flash program controller
package flash_prog_pkg;

   typedef enum logic [2:0] {
      PROTO_1S1S1S,
      PROTO_1S1S8S,
      PROTO_1S8S8S,
      PROTO_8S8S8S,
      PROTO_8D8D8D
   } proto_t;

   typedef enum logic [1:0] {ST_IDLE, ST_WALK, ST_SETTLE, ST_FAIL} prog_state_t;

   typedef struct packed {
      logic        we;
      logic        secure;
      logic [31:0] addr;
      logic [7:0]  data;
   } arr_beat_t;

endpackage : flash_prog_pkg

// >>> link_sync.sv
// two-flop synchroniser for the link pins
`timescale 1ns/1ps
`default_nettype none

module link_sync #(
   parameter int               WIDTH     = 10,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // pins and their synchronised copy
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   generate
      if (WIDTH < 1) begin : g_bad
         $error("link_sync width must be positive");
      end
      for (genvar i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_ff;
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               meta_ff     <= RESET_VAL[i];
               sync_out[i] <= RESET_VAL[i];
            end else begin
               meta_ff     <= async_in[i];
               sync_out[i] <= meta_ff;
            end
         end
      end
   endgenerate

endmodule : link_sync
`default_nettype wire

// >>> page_buffer.sv
// page buffer held in flip-flops with a per-byte loaded mark
`timescale 1ns/1ps
`default_nettype none

module page_buffer #(
   parameter int DATA_W = 8,
   parameter int DEPTH  = 512,
   parameter int IDX_W  = $clog2(DEPTH)
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // load side
   input  wire logic              clear,
   input  wire logic              wr_en,
   input  wire logic [IDX_W-1:0]  wr_idx,
   input  wire logic [DATA_W-1:0] wr_data,
   // drain side
   input  wire logic [IDX_W-1:0]  rd_idx,
   output logic      [DATA_W-1:0] rd_data,
   output logic                   rd_valid
);

   logic [DATA_W-1:0] mem_ff [DEPTH];
   logic [DEPTH-1:0]  vld_ff;

   generate
      if (DEPTH < 2 || (1 << IDX_W) < DEPTH) begin : g_bad
         $error("page_buffer depth and index width disagree");
      end
      for (genvar i = 0; i < DEPTH; i++) begin : g_ent
         wire logic hit = wr_en && (wr_idx == IDX_W'(i));
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               mem_ff[i] <= '0;
               vld_ff[i] <= 1'b0;
            end else begin
               // a later byte to the same slot overwrites the earlier one
               if (hit) begin
                  mem_ff[i] <= wr_data;
               end
               vld_ff[i] <= hit | (vld_ff[i] & ~clear);
            end
         end
      end
   endgenerate

   assign rd_data  = mem_ff[rd_idx];
   assign rd_valid = vld_ff[rd_idx];

endmodule : page_buffer
`default_nettype wire

// >>> link_host.sv
// host model that drives frames onto the flash link
`timescale 1ns/1ps
`default_nettype none
module link_host (
   // link pins
   output var logic       sck,
   output var logic       cs_n,
   output var logic [7:0] io
);
   logic [7:0] q[$];
   bit         ser;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      io = 8'h5A;
   end
   task automatic frame(input logic [2:0] p);
      cs_n = 1'b0;
      #100;
      foreach (q[i]) begin
         ser = (p == 3'h0) || (p < 3'h3 && (i == 0 || (p == 3'h1 && i < 5)));
         for (int b = 7; b >= (ser ? 0 : 7); b--) begin
            io = ser ? {7'h0, q[i][b]} : q[i];
            #50 sck = ~sck;
            if (p != 3'h4) #100 sck = ~sck;
            #50;
         end
      end
      // chip select rise launches; released pins show inverted data
      #100 cs_n = 1'b1;
      io = ~io;
      q.delete();
   endtask : frame
endmodule : link_host
`default_nettype wire

// >>> flash_program_control_bench.sv
// self-checking bench for the program controller
`timescale 1ns/1ps
`default_nettype none
module flash_program_control_bench;
   logic                      core_clk, rst, link_sck, link_cs_n, prot, sloc, ecc2, prior, eoff;
   logic [7:0]                link_io, cfg3, spo, frz, status;
   logic [2:0]                proto;
   logic [31:0]               taddr;
   flash_prog_pkg::arr_beat_t beat;
   integer                    miscompares = 0, total_checks = 0, seed = 24980, offs = 0;
   logic [39:0]               seen_q[$], exp_q[$];
   logic [7:0]                dq[$];
   link_host host (.sck(link_sck), .cs_n(link_cs_n), .io(link_io));
   flash_program_control DUT (.core_clk(core_clk), .rst(rst), .link_sck(link_sck),
      .link_cs_n(link_cs_n), .link_io(link_io), .link_proto(proto),
      .config_three_volatile(cfg3), .sector_protect_options(spo), .lock_freeze_reg(frz),
      .sector_protected(prot), .secure_region_locked(sloc), .ecc2_enable(ecc2),
      .arr_unit_prior(prior), .arr_beat(beat), .ecc_unit_off(eoff), .target_addr(taddr),
      .status_one_volatile(status));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(negedge core_clk) if (beat.we === 1'b1) seen_q.push_back({beat.addr, beat.data});
   always @(negedge core_clk) if (eoff === 1'b1) offs++;
   task chk(input logic [63:0] s, input logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   task automatic send(input logic [2:0] p, input logic [7:0] op, input logic [31:0] a,
                       input int n);
      @(negedge core_clk) proto = p;
      host.q.push_back(op);
      if (p > 3'h2) host.q.push_back(8'h00);
      if (n >= 0) for (int i = 3; i >= 0; i--) host.q.push_back(a[8*i +: 8]);
      for (int i = 0; i < n; i++) host.q.push_back(dq[i]);
      host.frame(p);
      repeat (8) @(negedge core_clk);
   endtask : send
   task wait_idle;
      for (int i = 0; i < 3000 && status[0] !== 1'b0; i++) @(negedge core_clk);
   endtask : wait_idle
   // loaded slots in slot order, later bytes overwrite on wrap
   function automatic void expect_beats(input logic [31:0] a, input logic [8:0] m, input int n);
      logic [7:0] img[512];
      bit         ld[512];
      logic [8:0] idx;
      exp_q.delete();
      for (int i = 0; i < n; i++) begin
         idx = 9'(a[8:0] + 9'(i)) & m;
         img[idx] = dq[i];
         ld[idx] = 1'b1;
      end
      for (int s = 0; s <= m; s++) if (ld[s]) exp_q.push_back({(a & ~{23'h0, m}) | 32'(s), img[s]});
   endfunction : expect_beats
   task automatic prog_run(input int p);
      logic [31:0] a;
      logic [8:0]  m;
      m = p[0] ? 9'h1FF : 9'h0FF;
      a = {20'h00010, 3'(p), 9'($random(seed)) & 9'h1FE};
      @(negedge core_clk) cfg3 = {3'h0, p[0], 4'h0};
      dq.delete();
      repeat (4) dq.push_back(8'($random(seed)));
      send(3'(p), 8'h11, 0, -1);
      chk(status[1], 1'b1);
      seen_q.delete();
      send(3'(p), 8'h33, a, 4);
      chk(taddr, a);
      chk(status[0], 1'b1);
      wait_idle();
      chk(status & 8'h43, 8'h00);
      expect_beats(a, m, 4);
      chk(seen_q.size(), exp_q.size());
      foreach (exp_q[i]) chk(seen_q[i], exp_q[i]);
   endtask : prog_run
   initial begin
      rst = 1'b1;
      proto = 3'h0;
      cfg3 = 8'h00;
      spo = 8'hFF;
      frz = 8'hFF;
      {prot, sloc, ecc2, prior} = 4'h0;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      repeat (4) @(negedge core_clk);
      dq = {8'hA5};
      send(3'h0, 8'h33, 32'h100, 1);
      chk(status[0], 1'b0);
      chk(seen_q.size(), 0);
      for (int p = 0; p < 5; p++) prog_run(p);
      @(negedge core_clk) prot = 1'b1;
      send(3'h0, 8'h11, 0, -1);
      send(3'h0, 8'h33, 32'h200, 1);
      chk(status & 8'h43, 8'h41);
      send(3'h0, 8'h11, 0, -1);
      chk(status & 8'h43, 8'h41);
      send(3'h0, 8'h22, 0, -1);
      chk(status & 8'h43, 8'h00);
      @(negedge core_clk) prot = 1'b0;
      for (int g = 0; g < 3; g++) begin
         @(negedge core_clk);
         spo = (g == 0) ? 8'hF7 : (g == 1) ? 8'hFE : 8'hFF;
         frz = (g == 2) ? 8'hFE : 8'hFF;
         send(3'h0, 8'h11, 0, -1);
         send(3'h0, 8'h55, 32'h0008_0000, 0);
         chk(status & 8'h43, 8'h41);
         send(3'h0, 8'h22, 0, -1);
      end
      @(negedge core_clk) frz = 8'hFF;
      send(3'h0, 8'h11, 0, -1);
      send(3'h0, 8'h22, 0, -1);
      chk(status & 8'h43, 8'h02);
      send(3'h0, 8'h55, 32'h0008_0000, 0);
      chk(status & 8'h43, 8'h03);
      wait_idle();
      chk(status, 8'h00);
      // units reprogrammed on purpose; secure start aligned, upper bits zero
      dq = {8'hF0, 8'h0F, 8'hFF, 8'h00};
      for (int k = 0; k < 4; k++) begin
         @(negedge core_clk) {sloc, ecc2, prior} = {k == 1, k == 3, k > 1};
         send(3'h0, 8'h11, 0, -1);
         send(3'h0, (k == 1) ? 8'h44 : 8'h33, {12'h0, k == 0, 19'h100}, 4);
         chk(status & 8'h43, (k == 2) ? 8'h03 : 8'h41);
         send(3'h0, 8'h22, 0, -1);
         wait_idle();
         if (k == 2) chk(offs, 4);
      end
      report_and_stop();
   end
   initial begin
      #2_000_000;
      miscompares++;
      report_and_stop();
   end
endmodule : flash_program_control_bench
`default_nettype wire
